// ==== dv/csd_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module csd_checker (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        fast_source_clk,
    input wire logic        slow_source_clk,
    input wire logic        sleep_enter,
    input wire logic        wake_up,
    input wire logic        fast_rc_osc_run,
    input wire logic        slow_rc_osc_run,
    input wire logic [1:0]  fast_osc_freq_sel,
    input wire logic [6:0]  fast_osc_trim,
    input wire logic        main_clk_tick,
    input wire logic        divided_high_clk_tick,
    input wire logic        core_clk_tick,
    input wire logic        instr_clk_tick,
    input wire logic        converter_clk_tick
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_fast_off;
        avs_write && !avs_waitrequest && avs_byteenable[0]
            && !avs_writedata[0] && avs_address[9:2] == csd_pkg::IDX_FAST_OSC;
    endsequence
    property p_answer; s_taken |=> !avs_waitrequest; endproperty
    property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    property p_rd_upper;
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
    endproperty
    property p_fast_off; s_fast_off |-> ##[1:3] !fast_rc_osc_run; endproperty
    property p_sleep;
        sleep_enter && !wake_up |-> ##[1:3] !slow_rc_osc_run;
    endproperty
    property p_wake; wake_up |-> ##[1:3] slow_rc_osc_run; endproperty
    property p_trim;
        $changed(fast_osc_trim) |-> $past(avs_write) || $past(avs_write, 2);
    endproperty
    property p_freq; fast_osc_freq_sel != csd_pkg::FREQ_PROHIBITED; endproperty
    property p_main;
        main_clk_tick |-> $past(fast_source_clk) || $past(slow_source_clk);
    endproperty
    property p_core;
        core_clk_tick |-> $past(main_clk_tick) || $past(divided_high_clk_tick);
    endproperty
    property p_instr; instr_clk_tick |=> !instr_clk_tick [*3]; endproperty
    property p_conv; converter_clk_tick |=> !converter_clk_tick [*3]; endproperty
    a_answer: assert property (p_answer)
        else $error("request not answered after one cycle");
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest low for more than one cycle");
    a_rd_upper: assert property (p_rd_upper)
        else $error("read data upper bits not zero");
    a_fast_off: assert property (p_fast_off)
        else $error("fast oscillator still enabled after disable");
    a_sleep: assert property (p_sleep)
        else $error("slow oscillator runs during sleep");
    a_wake: assert property (p_wake)
        else $error("slow oscillator not restarted on wake");
    a_trim: assert property (p_trim)
        else $error("trim changed without a write");
    a_freq: assert property (p_freq)
        else $error("prohibited frequency code driven");
    a_main: assert property (p_main)
        else $error("main tick without source pulse");
    a_core: assert property (p_core)
        else $error("core tick without selected tick");
    a_instr: assert property (p_instr)
        else $error("instruction ticks too close");
    a_conv: assert property (p_conv)
        else $error("converter ticks too close");
endmodule
bind csd_top csd_checker csd_checker_i (.*);
`default_nettype wire

// ==== dv/csd_osc_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// -------------------------------------------------------------------------
// Oscillators: edges come only while the matching run level is high.
// -------------------------------------------------------------------------
module csd_osc_model #(
    parameter int FAST_P = 3,
    parameter int SLOW_P = 11
) (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic fast_run,
    input  wire logic slow_run,
    output logic      fast_pulse,
    output logic      slow_pulse
);
    int fcnt;
    int scnt;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fcnt       <= 0;
            fast_pulse <= 1'b0;
        end else if (fast_run) begin
            fast_pulse <= (fcnt == FAST_P - 1);
            fcnt       <= (fcnt == FAST_P - 1) ? 0 : fcnt + 1;
        end else begin
            fast_pulse <= 1'b0;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scnt       <= 0;
            slow_pulse <= 1'b0;
        end else if (slow_run) begin
            slow_pulse <= (scnt == SLOW_P - 1);
            scnt       <= (scnt == SLOW_P - 1) ? 0 : scnt + 1;
        end else begin
            slow_pulse <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        clk_sys, arst_n, avs_read, avs_write, avs_waitrequest;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic        fsrc, ssrc, sleep_enter, wake_up, frun, srun;
    logic [1:0]  freq;
    logic [6:0]  trim;
    logic        t_main, t_high, t_mid, t_core, t_instr, t_conv, t_tmb;
    logic [7:0]  q, d;
    logic [8:0]  tin, tout;
    int          error_cnt, n_tests, seed, icnt[9], rec[9], ocnt[9];
    // In pulses per out pulse: main>high, high>mid, core>instr, high>conv,
    // fast>timer B, slow>timer B, fast>main, slow>main, main>core.
    assign tin  = {t_main, ssrc, fsrc, ssrc, fsrc, t_high, t_core, t_high,
                   t_main};
    assign tout = {t_core, t_main, t_main, t_tmb, t_tmb, t_conv, t_instr,
                   t_mid, t_high};
    csd_top csd_top_i (.clk_sys(clk_sys), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .fast_source_clk(fsrc),
        .slow_source_clk(ssrc), .sleep_enter(sleep_enter),
        .wake_up(wake_up), .fast_rc_osc_run(frun), .slow_rc_osc_run(srun),
        .fast_osc_freq_sel(freq), .fast_osc_trim(trim),
        .main_clk_tick(t_main), .divided_high_clk_tick(t_high),
        .mid_divided_clk_tick(t_mid), .core_clk_tick(t_core),
        .instr_clk_tick(t_instr), .converter_clk_tick(t_conv),
        .timer_b_clk_tick(t_tmb));
    csd_osc_model csd_osc_model_i (.clk_sys(clk_sys), .arst_n(arst_n),
        .fast_run(frun), .slow_run(srun), .fast_pulse(fsrc),
        .slow_pulse(ssrc));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 9; i++) begin
            if (tout[i]) begin
                rec[i]  <= icnt[i];
                icnt[i] <= int'(tin[i]);
                ocnt[i] <= ocnt[i] + 1;
            end else begin
                icnt[i] <= icnt[i] + int'(tin[i]);
            end
        end
    end
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Holds the request until waitrequest is seen low, then releases it.
    task automatic bus(input logic wr, input logic [7:0] idx, dat,
                       input logic [3:0] be);
        int k;
        k = 0;
        avs_address    <= {idx, 2'b00};
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= {24'h000000, dat};
        avs_byteenable <= be;
        do begin
            @(posedge clk_sys);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) begin
            error_cnt++;
            finish_test();
        end
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] idx, dat);
        bus(1'b1, idx, dat, 4'hf);
    endtask
    task automatic rdchk(input logic [7:0] idx, e, m);
        bus(1'b0, idx, 8'h00, 4'hf);
        check($sformatf("reg %h", idx), {24'h0, q & m}, {24'h0, e & m});
    endtask
    function automatic logic [7:0] exp_rd(input logic [7:0] idx, dat);
        case (idx)
            8'h33:   return dat & csd_pkg::MASK_UNLOCK_RD;
            8'h35:   return dat & csd_pkg::MASK_PERIPH;
            8'h34:   return dat;
            default: return 8'h00;
        endcase
    endfunction
    task automatic measure(input int p, input int e);
        int st, k;
        st = ocnt[p];
        k  = 0;
        while (ocnt[p] < st + 3 && k < 30000) begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 30000) begin
            error_cnt++;
            finish_test();
        end
        check($sformatf("ratio %0d", p), 32'(rec[p]), 32'(e));
    endtask
    initial begin
        seed = 32'h30663960;
        {arst_n, avs_read, avs_write, sleep_enter, wake_up} = 5'h00;
        {avs_address, avs_writedata, avs_byteenable} = '0;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        rdchk(8'h33, 8'h00, 8'hff);
        rdchk(8'h34, 8'h00, 8'hff);
        rdchk(8'h35, 8'h00, 8'hff);
        rdchk(8'h36, 8'h03, 8'h07);
        rdchk(8'h43, 8'h00, 8'hff);
        check("freq", {30'h0, freq}, 32'h1);
        for (int i = 0; i < 9; i++) begin
            d = 8'($random(seed));
            wr(8'h33 + 8'(i % 3), d);
            rdchk(8'h33 + 8'(i % 3), exp_rd(8'h33 + 8'(i % 3), d),
                  8'hff);
        end
        bus(1'b1, 8'h35, 8'h3c, 4'he);
        rdchk(8'h35, exp_rd(8'h35, d), 8'hff);
        wr(8'h33, 8'h00);
        d = 8'($random(seed));
        wr(8'h43, d);
        rdchk(8'h43, 8'h00, 8'hff);
        wr(8'h33, 8'h07);
        rdchk(8'h33, exp_rd(8'h33, 8'h07), 8'hff);
        wr(8'h43, d);
        rdchk(8'h43, d, 8'hff);
        check("trim", {25'h0, trim}, {25'h0, d[6:0]});
        wr(8'h33, 8'h00);
        wr(8'h43, ~d);
        rdchk(8'h43, d, 8'hff);
        wr(8'h36, 8'h05);
        check("freq", {30'h0, freq}, 32'h1);
        for (int c = 0; c < 4; c++) begin
            if (c != 2) begin
                wr(8'h36, {5'h00, 2'(c), 1'b1});
                repeat (2) @(posedge clk_sys);
                check("freq", {30'h0, freq}, 32'(c));
            end
        end
        wr(8'h35, 8'h00);
        for (int h = 0; h < 4; h++) begin
            wr(8'h34, 8'(h << 4));
            measure(0, 1 << h);
            measure(8, 1);
        end
        for (int m = 0; m < 8; m++) begin
            wr(8'h34, 8'(m << 1));
            measure(1, 2 << m);
        end
        wr(8'h34, 8'h21);
        measure(8, 4);
        measure(2, 4);
        for (int s = 0; s < 4; s++) begin
            wr(8'h34, 8'(s << 6));
            measure(s == 1 ? 7 : 6, 1);
        end
        // Converter runs from the fast source, the preferred setup.
        for (int c = 0; c < 4; c++) begin
            wr(8'h35, 8'(c << 4));
            measure(3, 2 << c);
        end
        for (int t = 0; t < 8; t++) begin
            wr(8'h35, 8'(t << 1));
            measure(4 + t % 2, 1 << (t / 2));
        end
        rdchk(8'h37, 8'h0b, 8'hff);
        wr(8'h36, 8'h02);
        repeat (3) @(posedge clk_sys);
        check("fast run", {31'h0, frun}, 32'h0);
        wr(8'h36, 8'h03);
        sleep_enter <= 1'b1;
        @(posedge clk_sys);
        sleep_enter <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check("slow run", {31'h0, srun}, 32'h0);
        wake_up <= 1'b1;
        @(posedge clk_sys);
        wake_up <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check("slow run", {31'h0, srun}, 32'h1);
        finish_test();
    end
endmodule
`default_nettype wire

// ==== rtl/csd_div.sv ====
`timescale 1ns/1ns
`default_nettype none
module csd_div #(
    parameter int CW = 8
) (
    input  wire logic          clk_sys,
    input  wire logic          arst_n,
    input  wire logic          tick_in,
    input  wire logic [CW-1:0] ratio_m1,
    output logic               tick_out
);

    logic [CW-1:0] cnt;
    logic [CW-1:0] cur_m1;

    // ----------------------------------------------------------------------
    // Counter; a new ratio is taken only at the end of a full period.
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '0;
            cur_m1 <= '0;
            tick_out <= 1'b0;
        end else if (tick_in) begin
            if (cnt >= cur_m1) begin
                cnt <= '0;
                cur_m1 <= ratio_m1;  // [RULE15]
                tick_out <= 1'b1;
            end else begin
                cnt <= cnt + 1'b1;
                tick_out <= 1'b0;
            end
        end else begin
            tick_out <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== rtl/csd_pkg.sv ====
package csd_pkg;

    // ----------------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ----------------------------------------------------------------------
    localparam logic [7:0] IDX_UNLOCK = 8'h33;
    localparam logic [7:0] IDX_SRC_DIV = 8'h34;
    localparam logic [7:0] IDX_PERIPH_DIV = 8'h35;
    localparam logic [7:0] IDX_FAST_OSC = 8'h36;
    localparam logic [7:0] IDX_STATUS = 8'h37;
    localparam logic [7:0] IDX_TRIM = 8'h43;

    // ----------------------------------------------------------------------
    // Values after hardware reset.
    // ----------------------------------------------------------------------
    localparam logic [7:0] RST_UNLOCK = 8'h00;
    localparam logic [7:0] RST_SRC_DIV = 8'h00;
    localparam logic [7:0] RST_PERIPH_DIV = 8'h00;
    localparam logic [7:0] RST_FAST_OSC = 8'h03;
    localparam logic [7:0] RST_TRIM = 8'h00;

    // ----------------------------------------------------------------------
    // Field positions.
    // ----------------------------------------------------------------------
    localparam int POS_UNLOCK = 0;
    localparam int POS_MAIN_SRC = 6;
    localparam int POS_HIGH_DIV = 4;
    localparam int POS_MID_DIV = 1;
    localparam int POS_CORE_SEL = 0;
    localparam int POS_CONV_DIV = 4;
    localparam int POS_TMB_DIV = 2;
    localparam int POS_TMB_SRC = 1;
    localparam int POS_FREQ_SEL = 1;
    localparam int POS_FAST_EN = 0;

    // Bits of the unlock register that read back; bits 1 and 2 are write-only and read as zero.
    localparam logic [7:0] MASK_UNLOCK_RD = 8'hf9;
    // Implemented bits of the peripheral divide register.
    localparam logic [7:0] MASK_PERIPH = 8'hfe;

    // Prohibited fast oscillator frequency code.
    localparam logic [1:0] FREQ_PROHIBITED = 2'h2;
    // Main source code that picks the slow source clock.
    localparam logic [1:0] MAIN_SRC_SLOW = 2'h1;
    // Instruction clock divides the core clock by this value plus one.
    localparam logic [7:0] INSTR_DIV_M1 = 8'h03;

    // Divide by two to the power exp, returned as terminal count.
    function automatic logic [7:0] pow2_m1(input logic [3:0] exp);
        logic [8:0] p;
        p = 9'h001 << exp;
        return p[7:0] - 8'h01;
    endfunction

endpackage

// ==== rtl/csd_srcsel.sv ====
`timescale 1ns/1ns
`default_nettype none
module csd_srcsel (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic sel,
    input  wire logic tick_a,
    input  wire logic tick_b,
    input  wire logic run_a,
    input  wire logic run_b,
    output logic      tick_out,
    output logic      sel_act
);

    logic cur_tick;
    logic cur_run;

    assign cur_tick = sel_act ? tick_b : tick_a;
    assign cur_run = sel_act ? run_b : run_a;

    // ----------------------------------------------------------------------
    // Switch only at the end of a period of the old source, or at once
    // when the old source has stopped, so no period is cut short.
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sel_act <= 1'b0;
            tick_out <= 1'b0;
        end else if (sel != sel_act && (cur_tick || !cur_run)) begin
            sel_act <= sel;  // [RULE15]
            tick_out <= 1'b0;
        end else begin
            tick_out <= cur_tick;
        end
    end

endmodule
`default_nettype wire

// ==== rtl/csd_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE1 - Writing zero to the fast oscillator enable stops the fast oscillator.
// RULE2 - Sleep halts the slow oscillator; wake-up restarts it automatically.
// RULE3 - Both oscillators are gated, selected and divided here before use.
// RULE4 - Main source field: 00 fast, 01 slow, 10 and 11 reserved.
// RULE5 - High divider makes divided high clock: main divided by 1,2,4,8.
// RULE6 - Mid divider divides divided high clock by 2 up to 256.
// RULE7 - Core select: 0 routes main clock, 1 routes divided high clock.
// RULE8 - Instruction clock is the core clock divided by four.
// RULE9 - Converter divider divides divided high clock by 2,4,8,16.
// RULE10 - Timer B divider divides its source by 1,2,4 for codes 00-10.
// RULE11 - Software should run from divided fast clock while converting.
// RULE12 - Timer B code 11 divides by 8; source bit picks fast or slow.
// RULE13 - Frequency field: 00 2MHz, 01 4MHz, 11 8MHz; 10 prohibited.
// RULE14 - Trim register accepts writes only while the unlock bit is set.
// RULE15 - Source and ratio changes never truncate or glitch any clock; the core select here can switch in mid-period of the divided high clock.
module csd_top (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        fast_source_clk,
    input  wire logic        slow_source_clk,
    input  wire logic        sleep_enter,
    input  wire logic        wake_up,
    output logic             fast_rc_osc_run,
    output logic             slow_rc_osc_run,
    output logic      [1:0]  fast_osc_freq_sel,
    output logic      [6:0]  fast_osc_trim,
    output logic             main_clk_tick,
    output logic             divided_high_clk_tick,
    output logic             mid_divided_clk_tick,
    output logic             core_clk_tick,
    output logic             instr_clk_tick,
    output logic             converter_clk_tick,
    output logic             timer_b_clk_tick
);

    // ----------------------------------------------------------------------
    // Register storage.
    // ----------------------------------------------------------------------
    logic [7:0] unlock_reg;
    logic [7:0] src_div_reg;
    logic [7:0] periph_div_reg;
    logic [7:0] fast_osc_reg;
    logic [7:0] trim_reg;
    logic       sleeping;

    logic       req;
    logic       wr_go;
    logic [7:0] idx;
    logic [7:0] next_rdata;

    logic [1:0] main_clk_source_sel;
    logic [1:0] high_div_sel;
    logic [2:0] mid_div_sel;
    logic       core_clk_sel;
    logic [1:0] converter_div_sel;
    logic [1:0] timer_b_div_sel;
    logic       timer_b_source_sel;
    logic       fast_osc_enable;
    logic       special_write_unlock;

    logic       fast_run;
    logic       slow_run;
    logic       main_sel_act;
    logic       tmb_sel_act;
    logic       timer_b_source_clk;
    logic       core_sel_act;

    assign main_clk_source_sel = src_div_reg[csd_pkg::POS_MAIN_SRC +: 2];
    assign high_div_sel = src_div_reg[csd_pkg::POS_HIGH_DIV +: 2];
    assign mid_div_sel = src_div_reg[csd_pkg::POS_MID_DIV +: 3];
    assign core_clk_sel = src_div_reg[csd_pkg::POS_CORE_SEL];
    assign converter_div_sel = periph_div_reg[csd_pkg::POS_CONV_DIV +: 2];
    assign timer_b_div_sel = periph_div_reg[csd_pkg::POS_TMB_DIV +: 2];
    assign timer_b_source_sel = periph_div_reg[csd_pkg::POS_TMB_SRC];
    assign fast_osc_enable = fast_osc_reg[csd_pkg::POS_FAST_EN];
    assign special_write_unlock = unlock_reg[csd_pkg::POS_UNLOCK];

    // ----------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then the answer for one cycle.
    // ----------------------------------------------------------------------
    assign req = avs_read | avs_write;
    assign idx = avs_address[9:2];
    assign wr_go = avs_write & ~avs_waitrequest & avs_byteenable[0];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        case (idx)
            csd_pkg::IDX_UNLOCK: begin
                next_rdata = unlock_reg & csd_pkg::MASK_UNLOCK_RD;
            end
            csd_pkg::IDX_SRC_DIV: begin
                next_rdata = src_div_reg;
            end
            csd_pkg::IDX_PERIPH_DIV: begin
                next_rdata = periph_div_reg;
            end
            csd_pkg::IDX_FAST_OSC: begin
                next_rdata = fast_osc_reg;
            end
            csd_pkg::IDX_STATUS: begin
                next_rdata = {3'h0, core_sel_act, tmb_sel_act,
                              main_sel_act, slow_run, fast_run};
            end
            csd_pkg::IDX_TRIM: begin
                next_rdata = trim_reg;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & avs_waitrequest) begin
            avs_readdata <= {24'h00_0000, next_rdata};
        end
    end

    // ----------------------------------------------------------------------
    // Control registers.
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            unlock_reg <= csd_pkg::RST_UNLOCK;
        end else if (wr_go && idx == csd_pkg::IDX_UNLOCK) begin
            unlock_reg <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            src_div_reg <= csd_pkg::RST_SRC_DIV;
        end else if (wr_go && idx == csd_pkg::IDX_SRC_DIV) begin
            src_div_reg <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            periph_div_reg <= csd_pkg::RST_PERIPH_DIV;
        end else if (wr_go && idx == csd_pkg::IDX_PERIPH_DIV) begin
            periph_div_reg <= avs_writedata[7:0] & csd_pkg::MASK_PERIPH;
        end
    end

    // A write of the prohibited frequency code leaves the field unchanged.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fast_osc_reg <= csd_pkg::RST_FAST_OSC;
        end else if (wr_go && idx == csd_pkg::IDX_FAST_OSC) begin
            fast_osc_reg[7:3] <= avs_writedata[7:3];
            fast_osc_reg[csd_pkg::POS_FAST_EN] <=
                avs_writedata[csd_pkg::POS_FAST_EN];  // [RULE1]
            if (avs_writedata[csd_pkg::POS_FREQ_SEL +: 2] !=
                csd_pkg::FREQ_PROHIBITED) begin
                fast_osc_reg[csd_pkg::POS_FREQ_SEL +: 2] <=
                    avs_writedata[csd_pkg::POS_FREQ_SEL +: 2];  // [RULE13]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            trim_reg <= csd_pkg::RST_TRIM;
        end else if (wr_go && idx == csd_pkg::IDX_TRIM &&
                     special_write_unlock) begin
            trim_reg <= avs_writedata[7:0];  // [RULE14]
        end
    end

    // ----------------------------------------------------------------------
    // Oscillator enables.
    // ----------------------------------------------------------------------
    // Wake-up wins over a sleep request in the same cycle.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sleeping <= 1'b0;
        end else if (wake_up) begin
            sleeping <= 1'b0;  // [RULE2]
        end else if (sleep_enter) begin
            sleeping <= 1'b1;  // [RULE2]
        end
    end

    assign fast_run = fast_rc_osc_run;
    assign slow_run = slow_rc_osc_run;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fast_rc_osc_run <= 1'b1;
            slow_rc_osc_run <= 1'b1;
            fast_osc_freq_sel <= 2'h1;
            fast_osc_trim <= 7'h00;
        end else begin
            fast_rc_osc_run <= fast_osc_enable & ~sleeping;  // [RULE1]
            slow_rc_osc_run <= ~sleeping;  // [RULE2]
            fast_osc_freq_sel <=
                fast_osc_reg[csd_pkg::POS_FREQ_SEL +: 2];  // [RULE13]
            fast_osc_trim <= trim_reg[6:0];
        end
    end

    // ----------------------------------------------------------------------
    // Front distributor: source selection and divider chain.
    // ----------------------------------------------------------------------
    csd_srcsel u_main_sel (  // [RULE3]
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .sel      (main_clk_source_sel == csd_pkg::MAIN_SRC_SLOW), // [RULE4]
        .tick_a   (fast_source_clk & fast_run),
        .tick_b   (slow_source_clk & slow_run),
        .run_a    (fast_run),
        .run_b    (slow_run),
        .tick_out (main_clk_tick),
        .sel_act  (main_sel_act)
    );

    csd_div #(.CW(8)) u_high_div (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .tick_in  (main_clk_tick),
        .ratio_m1 (csd_pkg::pow2_m1({2'h0, high_div_sel})),  // [RULE5]
        .tick_out (divided_high_clk_tick)
    );

    csd_div #(.CW(8)) u_mid_div (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .tick_in  (divided_high_clk_tick),
        .ratio_m1 (csd_pkg::pow2_m1({1'h0, mid_div_sel} + 4'h1)), // [RULE6]
        .tick_out (mid_divided_clk_tick)
    );

    csd_div #(.CW(8)) u_conv_div (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .tick_in  (divided_high_clk_tick),
        .ratio_m1 (csd_pkg::pow2_m1({2'h0, converter_div_sel} + 4'h1)),
        .tick_out (converter_clk_tick)  // [RULE9]
    );

    // Core source changes at a divided high clock tick or in any cycle without a main clock tick.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            core_sel_act <= 1'b0;
            core_clk_tick <= 1'b0;
        end else if (core_sel_act != core_clk_sel &&
                     (divided_high_clk_tick || !main_clk_tick)) begin
            core_sel_act <= core_clk_sel;  // [RULE15]
            core_clk_tick <= 1'b0;
        end else begin
            core_clk_tick <= core_sel_act ? divided_high_clk_tick
                                          : main_clk_tick;  // [RULE7]
        end
    end

    csd_div #(.CW(8)) u_instr_div (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .tick_in  (core_clk_tick),
        .ratio_m1 (csd_pkg::INSTR_DIV_M1),  // [RULE8]
        .tick_out (instr_clk_tick)
    );

    csd_srcsel u_tmb_sel (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .sel      (timer_b_source_sel),  // [RULE12]
        .tick_a   (fast_source_clk & fast_run),
        .tick_b   (slow_source_clk & slow_run),
        .run_a    (fast_run),
        .run_b    (slow_run),
        .tick_out (timer_b_source_clk),
        .sel_act  (tmb_sel_act)
    );

    csd_div #(.CW(8)) u_tmb_div (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .tick_in  (timer_b_source_clk),
        .ratio_m1 (csd_pkg::pow2_m1({2'h0, timer_b_div_sel})),
        .tick_out (timer_b_clk_tick)  // [RULE10] [RULE12]
    );

endmodule
`default_nettype wire
